// [common/dtc_pkg.sv]
// dtc_pkg: register map, field layout and codes for the dual timer control block
package dtc_pkg;

    // bus address width and data width
    localparam int unsigned DTC_AW = 8;
    localparam int unsigned DTC_DW = 32;

    // register offsets (byte addresses)
    localparam logic [7:0] DTC_OFF_CFG = 8'h00;
    localparam logic [7:0] DTC_OFF_FIRST_MODE = 8'h04;
    localparam logic [7:0] DTC_OFF_SECOND_MODE = 8'h08;
    localparam logic [7:0] DTC_OFF_CTL = 8'h0C;
    localparam logic [7:0] DTC_OFF_STATUS = 8'h50;
    localparam logic [7:0] DTC_OFF_ID = 8'h54;

    // reset values
    localparam logic [31:0] DTC_CTL_RESET = 32'h0000_0000;
    localparam logic [2:0] DTC_CFG_RESET = 3'h0;
    localparam logic [3:0] DTC_MODE_RESET = 4'h0;

    // writable bits of timer_control; everything else reads zero
    localparam logic [31:0] DTC_CTL_WMASK = 32'h0000_6F7F;

    // timer_control field positions
    localparam int unsigned DTC_FIRST_EN_BIT = 0;
    localparam int unsigned DTC_FIRST_STALL_BIT = 1;
    localparam int unsigned DTC_FIRST_EDGE_LSB = 2;
    localparam int unsigned DTC_RTC_EN_BIT = 4;
    localparam int unsigned DTC_FIRST_TRIG_BIT = 5;
    localparam int unsigned DTC_FIRST_INV_BIT = 6;
    localparam int unsigned DTC_SECOND_EN_BIT = 8;
    localparam int unsigned DTC_SECOND_STALL_BIT = 9;
    localparam int unsigned DTC_SECOND_EDGE_LSB = 10;
    localparam int unsigned DTC_SECOND_TRIG_BIT = 13;
    localparam int unsigned DTC_SECOND_INV_BIT = 14;

    // half mode register field positions
    localparam int unsigned DTC_MODE_MR_LSB = 0;
    localparam int unsigned DTC_MODE_CMR_BIT = 2;
    localparam int unsigned DTC_MODE_AMS_BIT = 3;

    // global_timer_config codes; any code with bit 2 set splits the timer
    localparam logic [2:0] DTC_CFG_WIDE = 3'h0;
    localparam logic [2:0] DTC_CFG_RTC = 3'h1;
    localparam int unsigned DTC_CFG_SPLIT_BIT = 2;

    // half mode field codes
    localparam logic [1:0] DTC_MR_PERIODIC = 2'h2;
    localparam logic [1:0] DTC_MR_CAPTURE = 2'h3;

    // capture edge-select codes; 2'h2 is reserved and selects nothing
    localparam logic [1:0] DTC_EDGE_RISE = 2'h0;
    localparam logic [1:0] DTC_EDGE_FALL = 2'h1;
    localparam logic [1:0] DTC_EDGE_BOTH = 2'h3;

    // status register bit positions
    localparam int unsigned DTC_ST_FIRST_RUN = 0;
    localparam int unsigned DTC_ST_SECOND_RUN = 1;
    localparam int unsigned DTC_ST_RTC_RUN = 2;
    localparam int unsigned DTC_ST_HALT = 3;
    localparam int unsigned DTC_ST_FIRST_PWM = 4;
    localparam int unsigned DTC_ST_SECOND_PWM = 5;
    localparam int unsigned DTC_ST_ARR_LSB = 8;

    // operating arrangement, one-hot
    typedef enum logic [3:0] {
        DTC_ARR_NONE = 4'b0001,
        DTC_ARR_WIDE = 4'b0010,
        DTC_ARR_RTC = 4'b0100,
        DTC_ARR_SPLIT = 4'b1000
    } dtc_arr_e;

endpackage

// [src/dtc_half.sv]
// dtc_half: per-half gating of run, capture edge, trigger and pwm level
module dtc_half
    import dtc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_stall_en,
    input wire logic i_halt,
    input wire logic [1:0] i_edge_sel,
    input wire logic i_trig_en,
    input wire logic i_invert,
    input wire logic i_pwm_mode,
    input wire logic i_capture_pin,
    input wire logic i_pwm_raw,
    input wire logic i_timeout,
    output logic o_run,
    output logic o_capture_event,
    output logic o_trigger,
    output logic o_pwm_out
);

    logic cap_meta_reg;
    logic cap_sync_reg;
    logic cap_prev_reg;
    logic rise;
    logic fall;
    logic edge_hit;

    // frozen while the debugger halts the core and stalling is on
    assign o_run = i_enable && !(i_stall_en && i_halt);

    // capture pin comes from outside; two flops before anything looks at it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cap_meta_reg <= 1'b0;
            cap_sync_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
        end else begin
            cap_meta_reg <= i_capture_pin;
            cap_sync_reg <= cap_meta_reg;
            cap_prev_reg <= cap_sync_reg;
        end
    end

    assign rise = cap_sync_reg && !cap_prev_reg;
    assign fall = !cap_sync_reg && cap_prev_reg;

    // edge selection; the reserved code matches no edge
    always_comb begin
        edge_hit = 1'b0;
        unique case (i_edge_sel)
            DTC_EDGE_RISE: edge_hit = rise;
            DTC_EDGE_FALL: edge_hit = fall;
            DTC_EDGE_BOTH: edge_hit = rise || fall;
            default: edge_hit = 1'b0;
        endcase
    end

    // registered outputs toward the counter, the converter and the pwm output
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_capture_event <= 1'b0;
            o_trigger <= 1'b0;
            o_pwm_out <= 1'b0;
        end else begin
            o_capture_event <= edge_hit && o_run;
            o_trigger <= i_timeout && i_trig_en;
            o_pwm_out <= i_pwm_mode && (i_pwm_raw ^ i_invert);
        end
    end

endmodule

// [src/dtc_timer_control.sv]
// dtc_timer_control: control, configuration and mode registers of a dual timer
//
// The implementer's own choice: strobed register access.
module dtc_timer_control
    import dtc_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = 32'h0000_0A5C // arbitrary value
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [dtc_pkg::DTC_AW-1:0] i_addr,
    input wire logic [dtc_pkg::DTC_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [dtc_pkg::DTC_DW-1:0] o_rdata,
    input wire logic i_debug_halt,
    input wire logic i_first_capture_pin,
    input wire logic i_second_capture_pin,
    input wire logic i_first_pwm_raw,
    input wire logic i_second_pwm_raw,
    input wire logic i_first_timeout,
    input wire logic i_second_timeout,
    output logic o_first_run,
    output logic o_second_run,
    output logic o_rtc_run,
    output logic o_wide_mode,
    output logic o_first_capture_event,
    output logic o_second_capture_event,
    output logic o_first_pwm_mode,
    output logic o_second_pwm_mode,
    output logic o_first_pwm_out,
    output logic o_second_pwm_out,
    output logic o_adc_first_trigger,
    output logic o_adc_second_trigger,
    output logic o_adc_trigger
);

    import dtc_pkg::*;

    // software-visible state
    logic [31:0] ctl_reg;
    logic [2:0] cfg_reg;
    logic [3:0] first_mode_reg;
    logic [3:0] second_mode_reg;

    // debug halt synchroniser
    logic halt_meta_reg;
    logic halt_sync_reg;

    // decoded arrangement and per-half controls
    dtc_arr_e arr;
    logic first_en;
    logic second_en;
    logic rtc_en;
    logic first_run_raw;
    logic second_run_raw;
    logic first_trig;
    logic second_trig;
    logic [31:0] status_word;
    logic [31:0] rdata_next;

    // pwm arrangement of one half from its mode register
    function automatic logic pwm_mode_f(input logic [3:0] mode, input dtc_arr_e a);
        logic ok;
        ok = (a == DTC_ARR_SPLIT);
        ok = ok && mode[DTC_MODE_AMS_BIT];
        ok = ok && !mode[DTC_MODE_CMR_BIT];
        ok = ok && (mode[DTC_MODE_MR_LSB +: 2] == DTC_MR_PERIODIC);
        return ok;
    endfunction

    // address compare, shared by read and write decode
    function automatic logic hit_f(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // timer_control: only documented fields take writes, reserved stay zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_reg <= DTC_CTL_RESET;
        end else if (i_wr && hit_f(i_addr, DTC_OFF_CTL)) begin
            ctl_reg <= i_wdata & DTC_CTL_WMASK;
        end
    end

    // global_timer_config
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_reg <= DTC_CFG_RESET;
        end else if (i_wr && hit_f(i_addr, DTC_OFF_CFG)) begin
            cfg_reg <= i_wdata[2:0];
        end
    end

    // first half mode register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            first_mode_reg <= DTC_MODE_RESET;
        end else if (i_wr && hit_f(i_addr, DTC_OFF_FIRST_MODE)) begin
            first_mode_reg <= i_wdata[3:0];
        end
    end

    // second half mode register; ignored while the timer is not split
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            second_mode_reg <= DTC_MODE_RESET;
        end else if (i_wr && hit_f(i_addr, DTC_OFF_SECOND_MODE)) begin
            second_mode_reg <= i_wdata[3:0];
        end
    end

    // halt comes from the debug domain, so it is synchronised first
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            halt_meta_reg <= 1'b0;
            halt_sync_reg <= 1'b0;
        end else begin
            halt_meta_reg <= i_debug_halt;
            halt_sync_reg <= halt_meta_reg;
        end
    end

    // arrangement decode; reserved codes leave every counter idle
    always_comb begin
        if (cfg_reg[DTC_CFG_SPLIT_BIT]) begin
            arr = DTC_ARR_SPLIT;
        end else if (cfg_reg == DTC_CFG_WIDE) begin
            arr = DTC_ARR_WIDE;
        end else if (cfg_reg == DTC_CFG_RTC) begin
            arr = DTC_ARR_RTC;
        end else begin
            arr = DTC_ARR_NONE;
        end
    end

    // enable bits per half, plus the rtc enable
    assign first_en = ctl_reg[DTC_FIRST_EN_BIT];
    assign second_en = ctl_reg[DTC_SECOND_EN_BIT];
    assign rtc_en = ctl_reg[DTC_RTC_EN_BIT];

    // which half may run in the chosen arrangement
    always_comb begin
        first_run_raw = 1'b0;
        second_run_raw = 1'b0;
        unique case (arr)
            DTC_ARR_WIDE: first_run_raw = first_en;
            DTC_ARR_SPLIT: begin
                first_run_raw = first_en;
                second_run_raw = second_en;
            end
            DTC_ARR_RTC: first_run_raw = 1'b0;
            DTC_ARR_NONE: first_run_raw = 1'b0;
        endcase
    end

    // rtc counting follows its own enable, not the half enables;
    // it keeps running through a debug halt so wall time stays true
    assign o_rtc_run = (arr == DTC_ARR_RTC) && rtc_en;
    assign o_wide_mode = (arr == DTC_ARR_WIDE) || (arr == DTC_ARR_RTC);

    // pwm arrangement of each half
    assign o_first_pwm_mode = pwm_mode_f(first_mode_reg, arr);
    assign o_second_pwm_mode = pwm_mode_f(second_mode_reg, arr);

    // first half: also drives the whole counter in the wide arrangement
    dtc_half u_first (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_enable(first_run_raw),
        .i_stall_en(ctl_reg[DTC_FIRST_STALL_BIT]),
        .i_halt(halt_sync_reg),
        .i_edge_sel(ctl_reg[DTC_FIRST_EDGE_LSB +: 2]),
        .i_trig_en(ctl_reg[DTC_FIRST_TRIG_BIT]),
        .i_invert(ctl_reg[DTC_FIRST_INV_BIT]),
        .i_pwm_mode(o_first_pwm_mode),
        .i_capture_pin(i_first_capture_pin),
        .i_pwm_raw(i_first_pwm_raw),
        .i_timeout(i_first_timeout),
        .o_run(o_first_run),
        .o_capture_event(o_first_capture_event),
        .o_trigger(first_trig),
        .o_pwm_out(o_first_pwm_out)
    );

    // second half: only meaningful in the split arrangement
    dtc_half u_second (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_enable(second_run_raw),
        .i_stall_en(ctl_reg[DTC_SECOND_STALL_BIT]),
        .i_halt(halt_sync_reg),
        .i_edge_sel(ctl_reg[DTC_SECOND_EDGE_LSB +: 2]),
        .i_trig_en(ctl_reg[DTC_SECOND_TRIG_BIT]),
        .i_invert(ctl_reg[DTC_SECOND_INV_BIT]),
        .i_pwm_mode(o_second_pwm_mode),
        .i_capture_pin(i_second_capture_pin),
        .i_pwm_raw(i_second_pwm_raw),
        .i_timeout(i_second_timeout),
        .o_run(o_second_run),
        .o_capture_event(o_second_capture_event),
        .o_trigger(second_trig),
        .o_pwm_out(o_second_pwm_out)
    );

    // converter trigger routing; each half's pulse is already gated
    assign o_adc_first_trigger = first_trig;
    assign o_adc_second_trigger = second_trig;
    assign o_adc_trigger = first_trig || second_trig;

    // status word shows the block's own live state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[DTC_ST_FIRST_RUN] = o_first_run;
        status_word[DTC_ST_SECOND_RUN] = o_second_run;
        status_word[DTC_ST_RTC_RUN] = o_rtc_run;
        status_word[DTC_ST_HALT] = halt_sync_reg;
        status_word[DTC_ST_FIRST_PWM] = o_first_pwm_mode;
        status_word[DTC_ST_SECOND_PWM] = o_second_pwm_mode;
        status_word[DTC_ST_ARR_LSB +: 4] = arr;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_f(i_addr, DTC_OFF_CTL)) begin
            rdata_next = ctl_reg & DTC_CTL_WMASK;
        end else if (hit_f(i_addr, DTC_OFF_CFG)) begin
            rdata_next = {29'h0000_0000, cfg_reg};
        end else if (hit_f(i_addr, DTC_OFF_FIRST_MODE)) begin
            rdata_next = {28'h000_0000, first_mode_reg};
        end else if (hit_f(i_addr, DTC_OFF_SECOND_MODE)) begin
            rdata_next = {28'h000_0000, second_mode_reg};
        end else if (hit_f(i_addr, DTC_OFF_STATUS)) begin
            rdata_next = status_word;
        end else if (hit_f(i_addr, DTC_OFF_ID)) begin
            rdata_next = ID_VALUE;
        end
    end

    // read data stands only in the cycle after the strobe; zero otherwise
    // so a stale value never looks like a fresh answer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule

// [tb/dtc_timer_control_monitor.sv]
// dtc_timer_control_monitor: port-level checks of the timer control block
module dtc_timer_control_mon
    import dtc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [dtc_pkg::DTC_AW-1:0] i_addr,
    input wire logic [dtc_pkg::DTC_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [dtc_pkg::DTC_DW-1:0] o_rdata,
    input wire logic i_debug_halt,
    input wire logic i_first_timeout,
    input wire logic i_second_timeout,
    input wire logic i_first_pwm_raw,
    input wire logic o_first_run,
    input wire logic o_second_run,
    input wire logic o_rtc_run,
    input wire logic o_wide_mode,
    input wire logic o_first_pwm_mode,
    input wire logic o_first_pwm_out,
    input wire logic o_adc_first_trigger,
    input wire logic o_adc_second_trigger,
    input wire logic o_adc_trigger
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] ctl_sh;
    logic [2:0] cfg_sh;
    logic [3:0] mode_sh;
    logic pwm_exp;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // shadow of software writes, so outputs can be tied to register state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_sh <= 32'h0;
            cfg_sh <= 3'h0;
            mode_sh <= 4'h0;
        end else if (i_wr) begin
            case (i_addr)
                DTC_OFF_CTL: ctl_sh <= i_wdata & DTC_CTL_WMASK;
                DTC_OFF_CFG: cfg_sh <= i_wdata[2:0];
                DTC_OFF_FIRST_MODE: mode_sh <= i_wdata[3:0];
                default: ;
            endcase
        end
    end
    // pwm level the first half should show one cycle later
    assign pwm_exp = o_first_pwm_mode && (i_first_pwm_raw ^ ctl_sh[6]);
    a_first_trig_fire: assert property (i_first_timeout && ctl_sh[5] |=> o_adc_first_trigger)
        else $error("first trigger missing");
    a_second_trig_gate: assert property (o_adc_second_trigger == $past(i_second_timeout && ctl_sh[13]))
        else $error("second trigger wrong");
    a_adc_route_or: assert property (o_adc_trigger == (o_adc_first_trigger || o_adc_second_trigger))
        else $error("converter trigger wrong");
    a_rtc_run_gate: assert property (o_rtc_run == (ctl_sh[4] && cfg_sh == DTC_CFG_RTC))
        else $error("rtc run wrong");
    a_first_run_on: assert property (ctl_sh[1:0] == 2'h1 && cfg_sh == DTC_CFG_WIDE |-> o_first_run)
        else $error("first half not running");
    a_stall_halt_freeze: assert property (i_debug_halt [*3] ##0 &ctl_sh[1:0] |-> !o_first_run)
        else $error("stalled half still running");
    a_second_run_gate: assert property (cfg_sh[2] && ctl_sh[9:8] == 2'h1 |-> o_second_run)
        else $error("second half not running");
    a_second_run_off: assert property (!ctl_sh[8] |-> !o_second_run)
        else $error("second half runs while disabled");
    a_wide_flag_cfg: assert property (o_wide_mode == (cfg_sh < 3'h2))
        else $error("wide flag wrong");
    a_pwm_mode_sel: assert property (o_first_pwm_mode == (cfg_sh[2] && mode_sh == 4'hA))
        else $error("pwm mode wrong");
    a_pwm_level_inv: assert property (o_first_pwm_out == $past(pwm_exp))
        else $error("pwm level wrong");
    a_ctl_read_back: assert property (i_rd && i_addr == DTC_OFF_CTL |=> o_rdata == $past(ctl_sh))
        else $error("control readback wrong");
endmodule

bind dtc_timer_control dtc_timer_control_mon u_mon (.*);

// [tb/dtc_timer_control_test.sv]
// dtc_timer_control_test: self-checking bench for the timer control block
module dtc_timer_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    import dtc_pkg::*;
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_debug_halt = 0;
    logic [7:0] i_addr = 0;
    logic [31:0] i_wdata = 0, o_rdata;
    logic i_first_capture_pin = 0, i_second_capture_pin = 0, i_first_pwm_raw = 0, i_second_pwm_raw = 0;
    logic i_first_timeout = 0, i_second_timeout = 0;
    logic o_first_run, o_second_run, o_rtc_run, o_wide_mode, o_first_capture_event, o_second_capture_event;
    logic o_first_pwm_mode, o_second_pwm_mode, o_first_pwm_out, o_second_pwm_out;
    logic o_adc_first_trigger, o_adc_second_trigger, o_adc_trigger;
    int failures = 0, comparisons = 0, ev1, ev2, ctl, cfg, mv, ex;
    dtc_timer_control u_dut (.*);
    always #10 i_clk = ~i_clk;
    // capture pulses counted over a whole window
    always @(posedge i_clk) begin
        if (o_first_capture_event === 1'b1) ev1++;
        if (o_second_capture_event === 1'b1) ev2++;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle strobe then an idle cycle, so strobes never get two writes in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        chk("rdata", o_rdata, exp);
    endtask
    // reference of run gating from the model registers
    task automatic runs(input int h);
        @(negedge i_clk);
        chk("first_run", o_first_run, ctl[0] && (cfg == 0 || cfg[2]) && !(ctl[1] && h));
        chk("second_run", o_second_run, ctl[8] && cfg[2] && !(ctl[9] && h));
        chk("rtc_run", o_rtc_run, ctl[4] && cfg == 1);
        chk("wide", o_wide_mode, cfg < 2);
    endtask
    task automatic close_out;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog sized well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(19234));
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 5; k++) rd(8'(4 * k), 32'h0);
        rd(DTC_OFF_STATUS, 32'(DTC_ARR_WIDE) << DTC_ST_ARR_LSB);
        $display("reset values done");
        // random control and config words; reserved bits must read back zero
        for (int k = 0; k < 12; k++) begin
            ctl = $urandom;
            cfg = $urandom % 8;
            wr(DTC_OFF_CTL, ctl);
            wr(DTC_OFF_CFG, cfg);
            rd(DTC_OFF_CTL, ctl & DTC_CTL_WMASK);
            runs(0);
        end
        // directed corners the random draws may miss: wide run and rtc run
        for (int k = 0; k < 2; k++) begin
            ctl = k ? 32'h0010 : 32'h0001;
            cfg = k;
            wr(DTC_OFF_CFG, cfg);
            wr(DTC_OFF_CTL, ctl);
            runs(0);
        end
        $display("random control done");
        ctl = 32'h0303;
        cfg = 4;
        wr(DTC_OFF_CFG, cfg);
        wr(DTC_OFF_CTL, ctl);
        @(posedge i_clk);
        i_debug_halt <= 1'b1;
        repeat (3) @(posedge i_clk);
        runs(1);
        ctl = 32'h0101;
        wr(DTC_OFF_CTL, ctl);
        runs(1);
        @(posedge i_clk);
        i_debug_halt <= 1'b0;
        $display("stall done");
        for (int en = 0; en < 2; en++) begin
            wr(DTC_OFF_CTL, en ? 32'h2121 : 32'h0101);
            @(posedge i_clk);
            i_first_timeout <= 1'b1;
            i_second_timeout <= 1'b1;
            @(posedge i_clk);
            i_first_timeout <= 1'b0;
            i_second_timeout <= 1'b0;
            @(negedge i_clk);
            chk("trig_first", o_adc_first_trigger, en);
            chk("trig_second", o_adc_second_trigger, en);
            chk("trig_adc", o_adc_trigger, en);
        end
        $display("trigger done");
        for (int code = 0; code < 4; code++) begin
            wr(DTC_OFF_CTL, 32'h0101 | code << 2 | code << 10);
            @(negedge i_clk);
            ev1 = 0;
            ev2 = 0;
            for (int lv = 1; lv >= 0; lv--) begin
                @(posedge i_clk);
                i_first_capture_pin <= lv[0];
                i_second_capture_pin <= lv[0];
                repeat (6) @(posedge i_clk);
            end
            ex = (code == 0 || code == 3) + (code == 1 || code == 3);
            chk("edge_first", ev1, ex);
            chk("edge_second", ev2, ex);
        end
        $display("edge select done");
        // 0x2 lacks the alternate select, 0xE has capture type set; only 0xA is pwm
        for (int mi = 0; mi < 3; mi++) begin
            mv = (mi == 2) ? 4'hA : (mi ? 4'hE : 4'h2);
            wr(DTC_OFF_FIRST_MODE, mv);
            wr(DTC_OFF_SECOND_MODE, mv);
            for (int inv = 0; inv < 2; inv++) begin
                wr(DTC_OFF_CTL, 32'h0101 | inv << 6 | inv << 14);
                for (int r = 0; r < 2; r++) begin
                    @(posedge i_clk);
                    i_first_pwm_raw <= r[0];
                    i_second_pwm_raw <= !r[0];
                    @(posedge i_clk);
                    @(negedge i_clk);
                    chk("pwm_mode", o_second_pwm_mode, mi == 2);
                    chk("pwm_mode_first", o_first_pwm_mode, mi == 2);
                    chk("pwm_first", o_first_pwm_out, (mi == 2) && (r[0] ^ inv[0]));
                    chk("pwm_second", o_second_pwm_out, (mi == 2) && (!r[0] ^ inv[0]));
                end
            end
        end
        $display("pwm done");
        close_out();
    end
endmodule
